// File: logic/video_input_capture.sv
// Capture of the parallel pixel port and the serial pixel link.
// Assumes all pins are asynchronous to clk and slow enough to sample.
//
// How it works
// - Drive enable selecting one of two shared sources
// - Any channel may feed any logical colour
// - Channel bit n weighs 2^(n-2), pixel clock sampled
// - Bit 9 weighs 128, same capture clock
// - Serial link deserialised into parallel pixel words
// - One link clock, five lanes, link clock sampling
// - Link accepted up to 90 MHz effective rate
// - Four selectable lane-to-bit mapping formats
`timescale 1ns/1ps
module video_input_capture
  import video_capture_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Parallel pixel port
  input wire logic port1_pixel_clock,
  input wire logic [video_capture_pkg::CHAN_W-1:0] port1_chan_a,
  input wire logic [video_capture_pkg::CHAN_W-1:0] port1_chan_b,
  input wire logic [video_capture_pkg::CHAN_W-1:0] port1_chan_c,
  // Shared source control
  input wire logic port1_active_source,
  output logic [1:0] port1_source_oe_n,
  // Serial pixel link
  input wire logic serial_link_clock_pair,
  input wire logic serial_lane_a_pos,
  input wire logic serial_lane_b_pos,
  input wire logic serial_lane_c_pos,
  input wire logic serial_lane_d_pos,
  input wire logic serial_lane_e_pos,
  // Configuration
  input wire video_capture_pkg::input_select_t input_select,
  input wire video_capture_pkg::link_format_t link_format,
  input wire logic [1:0] comp0_chan_sel,
  input wire logic [1:0] comp1_chan_sel,
  input wire logic [1:0] comp2_chan_sel,
  // Pixel output
  output logic pix_valid,
  output logic [video_capture_pkg::PIX_W-1:0] pix_data,
  input wire logic pix_ready,
  output logic pix_dropped,
  output logic link_too_fast
);
  import video_capture_pkg::*;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [CHAN_W-1:0] pick_chan(input logic [PIX_W-1:0] p,
                                                  input logic [1:0] sel);
    logic [CHAN_W-1:0] r;
    r = '0;
    if (sel == CHAN_SEL_A) r = p[CHAN_W-1:0];
    else if (sel == CHAN_SEL_B) r = p[2*CHAN_W-1:CHAN_W];
    else if (sel == CHAN_SEL_C) r = p[3*CHAN_W-1:2*CHAN_W];
    return r;
  endfunction

  function automatic logic [PIX_W-1:0] map_link(input link_format_t fmt,
                                                input logic [WORD_W-1:0] w);
    logic [6:0] a;
    logic [6:0] b;
    logic [6:0] c;
    logic [6:0] d;
    logic [6:0] e;
    logic [PIX_W-1:0] r;
    {e, d, c, b, a} = w;
    r = '0;
    unique case (fmt)
      FMT_8BIT: r = {c[6:2], d[2:0], 2'h0, b[6:1], c[1:0], 2'h0, a, b[0], 2'h0};
      FMT_9BIT: r = {c[6:4], d[5:0], 1'h0, b[6:2], c[3:0], 1'h0, a, b[1:0], 1'h0};
      FMT_10BIT_LANE_D: r = {c[6], d, e[1:0], b[6:3], c[5:0], a, b[2:0]};
      FMT_10BIT_LANE_E: r = {c, d[2:0], b, e[5:3], a, e[2:0]};
    endcase
    return r;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic p1_clk_last_q;
  logic link_clk_last_q;

  assign pins = {port1_pixel_clock, serial_link_clock_pair,
                 serial_lane_e_pos, serial_lane_d_pos, serial_lane_c_pos,
                 serial_lane_b_pos, serial_lane_a_pos,
                 port1_chan_c, port1_chan_b, port1_chan_a};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      p1_clk_last_q <= 1'b0;
      link_clk_last_q <= 1'b0;
    end else if (ce) begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      p1_clk_last_q <= sync2_q[SYNC_W-1];
      link_clk_last_q <= sync2_q[SYNC_W-2];
    end
  end

  wire [PIX_W-1:0] p1_pins_s;
  wire [LANES-1:0] lanes_s;
  wire p1_edge;
  wire link_edge;
  assign p1_pins_s = sync2_q[PIX_W-1:0];
  assign lanes_s = sync2_q[PIX_W+LANES-1:PIX_W];
  assign p1_edge = sync2_q[SYNC_W-1] & ~p1_clk_last_q;
  assign link_edge = sync2_q[SYNC_W-2] & ~link_clk_last_q;

  // ----------------------------------------
  // Parallel port channel swap
  // ----------------------------------------
  // per-component channel select
  wire [PIX_W-1:0] p1_swapped;
  assign p1_swapped = {pick_chan(p1_pins_s, comp2_chan_sel),
                       pick_chan(p1_pins_s, comp1_chan_sel),
                       pick_chan(p1_pins_s, comp0_chan_sel)};
  // bit 9 kept as channel MSB

  // ----------------------------------------
  // Shared source enable
  // ----------------------------------------
  logic [1:0] src_oe_n_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      src_oe_n_q <= SRC_OE_N_RST;
    end else if (ce) begin
      src_oe_n_q <= {~port1_active_source, port1_active_source};
    end
  end
  assign port1_source_oe_n = src_oe_n_q;

  // ----------------------------------------
  // Serial link deserialiser
  // ----------------------------------------
  logic [WORD_W-1:0] ser_q;
  logic [2:0] ser_cnt_q;
  logic [7:0] gap_cnt_q;
  logic too_fast_q;
  wire [WORD_W-1:0] ser_d;
  wire word_done;
  wire gap_short;
  genvar g;
  // shift each lane one bit per edge
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      assign ser_d[g*SER_BITS +: SER_BITS] =
        {ser_q[g*SER_BITS +: SER_BITS-1], lanes_s[g]};
    end
  endgenerate
  assign word_done = link_edge & (ser_cnt_q == SER_CNT_LAST);
  assign gap_short = link_edge & (gap_cnt_q < 8'(LINK_GAP_CYC));

  always_ff @(posedge clk) begin
    if (!resetn) begin
      ser_q <= '0;
      ser_cnt_q <= '0;
      gap_cnt_q <= '0;
      too_fast_q <= 1'b0;
    end else if (ce) begin
      if (link_edge) begin
        ser_q <= ser_d;
        ser_cnt_q <= word_done ? 3'h0 : ser_cnt_q + 3'h1;
        gap_cnt_q <= '0;
      end else if (gap_cnt_q != 8'hff) begin
        gap_cnt_q <= gap_cnt_q + 8'h1;
      end
      too_fast_q <= gap_short;
    end
  end
  assign link_too_fast = too_fast_q;

  wire [PIX_W-1:0] link_pix;
  assign link_pix = map_link(link_format, ser_d);

  // ----------------------------------------
  // Capture stage into FIFO
  // ----------------------------------------
  pixel_stream_if #(.W(PIX_W)) fill_if ();
  pixel_stream_if #(.W(PIX_W)) drain_if ();

  logic cap_valid_q;
  logic [PIX_W-1:0] cap_data_q;
  logic drop_q;
  wire sel_p2;
  wire new_word;
  wire [PIX_W-1:0] new_data;
  wire cap_stall;
  assign sel_p2 = (input_select == IN_PORT2);
  // one word per pixel clock edge on port 1, one per seventh link clock edge on the link
  assign new_word = sel_p2 ? word_done : p1_edge;
  assign new_data = sel_p2 ? link_pix : p1_swapped;
  assign cap_stall = cap_valid_q & ~fill_if.ready;
  assign fill_if.valid = cap_valid_q;
  assign fill_if.data = cap_data_q;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      cap_valid_q <= 1'b0;
      cap_data_q <= '0;
      drop_q <= 1'b0;
    end else if (ce) begin
      cap_valid_q <= new_word | cap_stall;
      if (new_word && !cap_stall) cap_data_q <= new_data;
      drop_q <= new_word & cap_stall;
    end
  end
  assign pix_dropped = drop_q;

  pixel_fifo #(.WIDTH(PIX_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .wr(fill_if.snk),
    .rd(drain_if.src)
  );

  // ----------------------------------------
  // Registered output stage
  // ----------------------------------------
  logic out_valid_q;
  logic [PIX_W-1:0] out_data_q;
  wire out_free;
  assign out_free = ~out_valid_q | pix_ready;
  assign drain_if.ready = out_free;

  always_ff @(posedge clk) begin
    if (!resetn) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (ce && out_free) begin
      out_valid_q <= drain_if.valid;
      if (drain_if.valid) out_data_q <= drain_if.data;
    end
  end
  assign pix_valid = out_valid_q;
  assign pix_data = out_data_q;
endmodule // video_input_capture

// File: include/video_capture_pkg.sv
// Constants and types shared by the video input capture block.
// Assumes one 40 MHz core clock samples every pin of both ports.
package video_capture_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int CHAN_W = 10;
  localparam int NUM_CHAN = 3;
  localparam int PIX_W = CHAN_W * NUM_CHAN;
  // Bit n of a channel weighs 2^(n-2): two fraction bits
  localparam int FRAC_BITS = 2;
  localparam int LANES = 5;
  localparam int SER_BITS = 7;
  localparam int WORD_W = LANES * SER_BITS;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_W = 2 + LANES + PIX_W;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 40_000_000;
  localparam int LINK_MAX_HZ = 90_000_000;
  // Fewest core cycles between two link clock edges still accepted
  localparam int LINK_GAP_CYC_RAW = (CLK_HZ + LINK_MAX_HZ - 1) / LINK_MAX_HZ;
  localparam int LINK_GAP_CYC = (LINK_GAP_CYC_RAW < 1) ? 1 : LINK_GAP_CYC_RAW;

  // ----------------------------------------
  // Reset values and encodings
  // ----------------------------------------
  localparam logic [1:0] SRC_OE_N_RST = 2'h3;
  localparam logic [2:0] SER_CNT_LAST = 3'h6;
  localparam logic [1:0] CHAN_SEL_A = 2'h0;
  localparam logic [1:0] CHAN_SEL_B = 2'h1;
  localparam logic [1:0] CHAN_SEL_C = 2'h2;

  typedef enum logic [1:0] {
    FMT_8BIT,
    FMT_9BIT,
    FMT_10BIT_LANE_D,
    FMT_10BIT_LANE_E
  } link_format_t;

  typedef enum logic {
    IN_PORT1,
    IN_PORT2
  } input_select_t;

endpackage

// File: include/pixel_stream_if.sv
// Valid/ready pixel stream between the capture logic and its FIFO.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface pixel_stream_if #(parameter int W = 30) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: logic/pixel_fifo.sv
// Small first-in first-out buffer for captured pixel words.
// Assumes DEPTH is a power of two and at least two.
`timescale 1ns/1ps
module pixel_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Fill side
  pixel_stream_if.snk wr,
  // Drain side
  pixel_stream_if.src rd
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] cnt_q;
  wire push;
  wire pop;

  // ----------------------------------------
  // Flags and handshakes
  // ----------------------------------------
  assign wr.ready = (cnt_q != FULL_CNT);
  assign rd.valid = (cnt_q != '0);
  assign rd.data = mem[rd_ptr_q];
  assign push = wr.valid & wr.ready;
  assign pop = rd.valid & rd.ready;

  // ----------------------------------------
  // Storage and pointers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_q] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) wr_ptr_q <= wr_ptr_q + PW'(1);
      if (pop) rd_ptr_q <= rd_ptr_q + PW'(1);
      if (push && !pop) cnt_q <= cnt_q + CW'(1);
      else if (pop && !push) cnt_q <= cnt_q - CW'(1);
    end
  end
endmodule // pixel_fifo

// File: verification/video_input_capture_chk.sv
// Port assertions for the capture block.
// Bound to every video_input_capture instance.
`timescale 1ns/1ps
module video_input_capture_chk
  import video_capture_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // Pins
  input wire logic port1_pixel_clock,
  input wire logic serial_link_clock_pair,
  input wire logic port1_active_source,
  input wire logic [1:0] port1_source_oe_n,
  input wire video_capture_pkg::input_select_t input_select,
  // Output stream
  input wire logic pix_valid,
  input wire logic [video_capture_pkg::PIX_W-1:0] pix_data,
  input wire logic pix_ready,
  input wire logic pix_dropped
);
  // ----
  // Cycles since a clock pin moved
  // ----
  logic pclk_q, lclk_q;
  logic [3:0] quiet_q, quiet_d;
  assign quiet_d = (pclk_q != port1_pixel_clock || lclk_q != serial_link_clock_pair) ? 4'h0
    : (quiet_q == 4'hf) ? quiet_q : quiet_q + 4'h1;
  always_ff @(posedge clk) begin
    pclk_q <= port1_pixel_clock;
    lclk_q <= serial_link_clock_pair;
    quiet_q <= resetn ? quiet_d : 4'h0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----
  // Assertions
  // ----
  // enable tracks source
  a_oe_follows_src: assert property (ce |=>
    port1_source_oe_n == ($past(port1_active_source) ? 2'h1 : 2'h2)) else $error("bad enable");
  a_one_source_on: assert property (port1_source_oe_n != 2'h0)
    else $error("both enabled");
  a_reset_all_off: assert property ($rose(resetn) |->
    port1_source_oe_n == 2'h3 && !pix_valid) else $error("reset state");
  a_pixel_latency: assert property (ce && input_select == IN_PORT1 && !pix_valid
    && $rose(port1_pixel_clock) |-> ##[3:8] pix_valid) else $error("no capture");
  a_idle_no_word: assert property (quiet_q >= 4'ha && !pix_valid |=> !pix_valid)
    else $error("spurious word");
  a_valid_held: assert property (pix_valid && !pix_ready |=>
    pix_valid && $stable(pix_data)) else $error("output not held");
  a_drop_when_full: assert property (pix_dropped |-> pix_valid)
    else $error("drop while free");
  a_drop_single: assert property (pix_dropped |=> !pix_dropped)
    else $error("long drop");
  a_freeze_holds: assert property (!ce |=> $stable(pix_valid) && $stable(pix_data)
    && $stable(port1_source_oe_n)) else $error("moved while frozen");
  c_drop: cover property (pix_dropped);
  c_serial_word: cover property (input_select == IN_PORT2 && pix_valid && pix_ready);
  c_second_source: cover property (port1_source_oe_n == 2'h1);
endmodule // video_input_capture_chk

bind video_input_capture video_input_capture_chk i_chk (
  .clk, .resetn, .ce, .port1_pixel_clock, .serial_link_clock_pair, .port1_active_source,
  .port1_source_oe_n, .input_select, .pix_valid, .pix_data, .pix_ready, .pix_dropped
);

// File: verification/video_source_model.sv
// Stand-in for the two parallel sources and the serial link source.
// Tasks are started just after a core clock edge.
`timescale 1ns/1ps
module video_source_model (
  // Shared source enables
  input wire logic [1:0] port1_source_oe_n,
  // Parallel port
  output logic port1_pixel_clock,
  output logic [29:0] port1_word,
  // Serial link
  output logic serial_link_clock_pair,
  output logic [4:0] lanes
);
  logic [29:0] src_q [2];
  // ----
  // Shared bus
  // ----
  // idle source released, reads low
  assign port1_word = (port1_source_oe_n[0] ? 30'h0 : src_q[0])
    | (port1_source_oe_n[1] ? 30'h0 : src_q[1]);
  initial begin
    port1_pixel_clock = 1'b0;
    serial_link_clock_pair = 1'b0;
    lanes = 5'h0;
    src_q = '{30'h0, 30'h0};
  end
  // ----
  // Transfers
  // ----
  // caller gives justified words
  task automatic send_par(input int s, input logic [29:0] w);
    src_q[s] = w;
    #100 port1_pixel_clock = 1'b1;
    #100 port1_pixel_clock = 1'b0;
  endtask
  task automatic send_ser(input logic [34:0] w);
    for (int i = 6; i >= 0; i--) begin
      for (int l = 0; l < 5; l++)
        lanes[l] = w[7*l+i];
      #100 serial_link_clock_pair = 1'b1;
      #100 serial_link_clock_pair = 1'b0;
    end
    // Lanes back to pulldown level
    lanes = 5'h0;
  endtask
endmodule // video_source_model

// File: verification/test_video_input_capture.sv
// Self-checking bench for the video input capture block.
// Needs the source model and the bound checker.
`timescale 1ns/1ps
module test_video_input_capture;
  import video_capture_pkg::*;
  // ----
  // Signals
  // ----
  logic clk, resetn, ce, port1_active_source, pix_ready, stall;
  logic port1_pixel_clock, serial_link_clock_pair, pix_valid, pix_dropped, link_too_fast;
  logic [1:0] port1_source_oe_n, comp0_chan_sel, comp1_chan_sel, comp2_chan_sel;
  logic [4:0] lanes;
  logic [29:0] p1_word, pix_data, w;
  logic [34:0] wl;
  input_select_t input_select;
  link_format_t link_format;
  logic [29:0] exp_q [$];
  logic [5:0] sel_tab [8] = '{6'h24, 6'h21, 6'h18, 6'h12, 6'h09, 6'h06, 6'h3f, 6'h00};
  int errors, n_checks, n_drop, n_fast, cyc;

  video_input_capture i_dut (
    .clk, .resetn, .ce, .port1_pixel_clock, .port1_chan_a(p1_word[9:0]),
    .port1_chan_b(p1_word[19:10]), .port1_chan_c(p1_word[29:20]), .port1_active_source,
    .port1_source_oe_n, .serial_link_clock_pair, .serial_lane_a_pos(lanes[0]),
    .serial_lane_b_pos(lanes[1]), .serial_lane_c_pos(lanes[2]), .serial_lane_d_pos(lanes[3]),
    .serial_lane_e_pos(lanes[4]), .input_select, .link_format, .comp0_chan_sel,
    .comp1_chan_sel, .comp2_chan_sel, .pix_valid, .pix_data, .pix_ready, .pix_dropped,
    .link_too_fast
  );
  video_source_model i_src (
    .port1_source_oe_n, .port1_pixel_clock, .port1_word(p1_word), .serial_link_clock_pair,
    .lanes
  );
  // ----
  // Helpers
  // ----
  task automatic check(input logic [29:0] seen, input logic [29:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    if (errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) begin
      errors++;
      $display("ERROR %0t: output stalled", $time);
    end
    repeat (4) @(posedge clk);
  endtask
  function automatic logic [9:0] pick(input logic [29:0] x, input logic [1:0] s);
    return (s == 2'h3) ? 10'h0 : x[10*s +: 10];
  endfunction
  function automatic logic [29:0] ser_exp(input logic [34:0] x, input link_format_t f);
    logic [6:0] a, b, c, d, e;
    {e, d, c, b, a} = x;
    case (f)
      FMT_8BIT: return {c[6:2], d[2:0], 2'h0, b[6:1], c[1:0], 2'h0, a, b[0], 2'h0};
      FMT_9BIT: return {c[6:4], d[5:0], 1'h0, b[6:2], c[3:0], 1'h0, a, b[1:0], 1'h0};
      FMT_10BIT_LANE_D: return {c[6], d, e[1:0], b[6:3], c[5:0], a, b[2:0]};
      default: return {c, d[2:0], b, e[5:3], a, e[2:0]};
    endcase
  endfunction
  // ----
  // Clock, timeout, sink, monitor
  // ----
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      stop_test();
    end
  end
  always @(posedge clk)
    #2 pix_ready = stall ? 1'b0 : 1'($urandom % 2);
  always @(posedge clk) begin
    if (resetn && pix_dropped === 1'b1)
      n_drop++;
    if (resetn && link_too_fast === 1'b1)
      n_fast++;
    if (resetn && ce && pix_valid === 1'b1 && pix_ready)
      check(pix_data, exp_q.size() ? exp_q.pop_front() : 30'hx);
  end
  // ----
  // Scenarios
  // ----
  initial begin
    w = 30'($urandom(46));
    resetn = 1'b0;
    ce = 1'b1;
    stall = 1'b0;
    pix_ready = 1'b0;
    port1_active_source = 1'b0;
    input_select = IN_PORT1;
    link_format = FMT_8BIT;
    {comp2_chan_sel, comp1_chan_sel, comp0_chan_sel} = 6'h24;
    repeat (6) @(posedge clk);
    #2 resetn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #2 port1_active_source = i[0];
      {comp2_chan_sel, comp1_chan_sel, comp0_chan_sel} = sel_tab[i];
      w = 30'({$urandom, $urandom});
      if (i[0])
        w = w & 30'h3fcff3fc;
      exp_q.push_back({pick(w, comp2_chan_sel), pick(w, comp1_chan_sel), pick(w, comp0_chan_sel)});
      i_src.send_par(i[0], w);
      drain();
    end
    @(posedge clk);
    #2 stall = 1'b1;
    port1_active_source = 1'b0;
    {comp2_chan_sel, comp1_chan_sel, comp0_chan_sel} = 6'h24;
    @(posedge clk);
    #2;
    for (int i = 0; i < 7; i++) begin
      w = 30'($urandom);
      if (i < 6)
        exp_q.push_back(w);
      i_src.send_par(0, w);
    end
    // Frozen core neither moves nor loses words
    ce = 1'b0;
    repeat (10) @(posedge clk);
    stall = 1'b0;
    repeat (6) @(posedge clk);
    #2 ce = 1'b1;
    drain();
    check(30'(n_drop), 30'h1);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #2 link_format = link_format_t'(i / 2);
      input_select = IN_PORT2;
      wl = 35'({$urandom, $urandom});
      exp_q.push_back(ser_exp(wl, link_format));
      i_src.send_ser(wl);
      drain();
    end
    check(30'(n_fast), 30'h0);
    stop_test();
  end
endmodule // test_video_input_capture
